// [logic/css_map.svh]
// register offsets, reset values and timing counts
// assumes byte addressing on a 32-bit apb bus
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
`define CSS_OFF_TRIM 12'h000
`define CSS_OFF_STAT 12'h004
`define CSS_OFF_CTRL 12'h008
`define CSS_CTRL_WAKE_BIT 0
`define CSS_RST_SEL 4'h1
`define CSS_RST_SUT 2'h2
`define CSS_RST_OPT 1'h1
`define CSS_RST_TRIM 8'h00
`define CSS_T_EXTRA_SHORT_US 4100
`define CSS_T_EXTRA_LONG_US 65000
`define CSS_WDT_SHORT 17'h01000
`define CSS_WDT_LONG 65536
`define CSS_CK_6 17'h00006
`define CSS_CK_18 17'h00012
`define CSS_CK_1K 17'h00400
`define CSS_CK_32K 32768
`define CSS_LOAD_CYC 17'h00002
`endif

// [logic/css_pkg.sv]
// types for the clock source start-up block
// assumes css_map.svh holds the numbers
package css_pkg;
  typedef enum logic [2:0] {
    CSS_SRC_EXTCLK = 3'b000,
    CSS_SRC_IRC = 3'b001,
    CSS_SRC_ERC = 3'b010,
    CSS_SRC_LFXT = 3'b011,
    CSS_SRC_NONE = 3'b100
  } css_src_t;
  typedef enum logic [1:0] {
    CSS_ST_LOAD = 2'b00,
    CSS_ST_EXTRA = 2'b01,
    CSS_ST_CK = 2'b10,
    CSS_ST_RUN = 2'b11
  } css_state_t;
  typedef struct packed {
    logic [3:0] sel;
    logic [1:0] startup_time_fuses;
    logic opt;
  } css_fuse_t;
  typedef struct packed {
    css_src_t src;
    logic [1:0] range;
    logic [16:0] ck;
    logic [16:0] wdt;
  } css_dec_t;
  typedef struct packed {
    logic [20:0] zero;
    logic opt_warn;
    logic [1:0] startup_time_fuses;
    logic [1:0] range;
    css_src_t src;
    css_state_t phase;
    logic busy;
  } css_stat_t;
endpackage

// [logic/css_clock_startup.sv]
// clock source decode, start-up delay and trim register
// assumes fuses, ticks and calibration byte arrive from pins
//
// Summary of operation
// - fuse code 1001 selects the low-frequency watch crystal
// - crystal start-up: 1K+4.1ms, 1K+65ms, 32K+65ms, 11 reserved
// - codes 0101 to 1000 select external RC, ranges low to high
// - external RC: 18 CK plus none, 4.1ms, 65ms; 11 is 6+4.1ms
// - codes 0001 to 0100 select internal RC at 1, 2, 4, 8 MHz
// - unprogrammed defaults are select 0001 and start-up 10
// - internal RC: 6 CK plus none, 4.1ms, 65ms; 11 reserved
// - reset copies the factory calibration byte into the trim register
// - trim value raises internal RC frequency monotonically
// - watchdog oscillator times the reset delay whatever the source
// - code 0000 selects an external clock on the input pin
// - external clock: 6 CK plus none, 4.1ms, 65ms; 11 reserved
// - fuse bits read 1 unprogrammed, 0 programmed
// - extra delays are 4096 and 65536 watchdog cycles
// - wake-up uses only the start-up count; reset adds the delay
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "css_map.svh"
module css_clock_startup #(
  parameter int EXTRA_LONG_WDT = `CSS_WDT_LONG,
  parameter int LFXT_LONG_CK = `CSS_CK_32K
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire css_pkg::css_fuse_t fuses,
  input wire logic [7:0] factory_cal_byte,
  input wire logic src_clk_tick,
  input wire logic wdt_osc_tick,
  output css_pkg::css_src_t source_kind,
  output logic [1:0] source_range,
  output logic [7:0] trim_value,
  output logic wdt_osc_request,
  output logic core_clk_enable
);
  import css_pkg::*;

  // ****************************************
  // parameter checks
  // ****************************************
  if (EXTRA_LONG_WDT < 1 || EXTRA_LONG_WDT > 65536) begin : g_chk_wdt
    $error("EXTRA_LONG_WDT out of range");
  end
  if (LFXT_LONG_CK < 1 || LFXT_LONG_CK > 65536) begin : g_chk_ck
    $error("LFXT_LONG_CK out of range");
  end
  localparam logic [16:0] WDT_LONG = 17'(EXTRA_LONG_WDT);
  localparam logic [16:0] CK_LONG = 17'(LFXT_LONG_CK);

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam logic [16:0] SYNC_RST = {`CSS_RST_SEL, `CSS_RST_SUT,
    `CSS_RST_OPT, `CSS_RST_TRIM, 2'b00};
  logic [16:0] sync1_reg;
  logic [16:0] sync2_reg;
  logic [1:0] tick_d_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      tick_d_reg <= 2'b00;
    end else begin
      sync1_reg <= {fuses, factory_cal_byte, src_clk_tick, wdt_osc_tick};
      sync2_reg <= sync1_reg;
      tick_d_reg <= sync2_reg[1:0];
    end
  end
  css_fuse_t fz;
  logic [7:0] cal_sync;
  logic src_tick;
  logic wdt_tick;
  assign fz = sync2_reg[16:10];
  assign cal_sync = sync2_reg[9:2];
  assign src_tick = sync2_reg[1] & ~tick_d_reg[1];
  assign wdt_tick = sync2_reg[0] & ~tick_d_reg[0];

  // ****************************************
  // fuse decode
  // ****************************************
  css_dec_t dec;
  logic [16:0] wdt_sel3;
  always_comb begin
    case (fz.startup_time_fuses)
      2'b00: wdt_sel3 = 17'h00000;
      2'b01: wdt_sel3 = `CSS_WDT_SHORT;
      default: wdt_sel3 = WDT_LONG;
    endcase
    dec.src = CSS_SRC_NONE;
    dec.range = 2'b00;
    dec.ck = CK_LONG;
    dec.wdt = WDT_LONG;
    case (fz.sel)
      4'h9: begin
        dec.src = CSS_SRC_LFXT;
        case (fz.startup_time_fuses)
          2'b00: begin
            dec.ck = `CSS_CK_1K;
            dec.wdt = `CSS_WDT_SHORT;
          end
          2'b01: dec.ck = `CSS_CK_1K;
          default: dec.ck = CK_LONG;
        endcase
      end
      4'h5, 4'h6, 4'h7, 4'h8: begin
        dec.src = CSS_SRC_ERC;
        dec.range = 2'(fz.sel - 4'h5);
        dec.ck = `CSS_CK_18;
        dec.wdt = wdt_sel3;
        if (fz.startup_time_fuses == 2'b11) begin
          dec.ck = `CSS_CK_6;
          dec.wdt = `CSS_WDT_SHORT;
        end
      end
      4'h1, 4'h2, 4'h3, 4'h4: begin
        dec.src = CSS_SRC_IRC;
        dec.range = 2'(fz.sel - 4'h1);
        dec.ck = `CSS_CK_6;
        dec.wdt = wdt_sel3;
      end
      4'h0: begin
        dec.src = CSS_SRC_EXTCLK;
        dec.ck = `CSS_CK_6;
        dec.wdt = wdt_sel3;
      end
      default: begin
        dec.src = CSS_SRC_NONE;
      end
    endcase
  end

  // ****************************************
  // apb slave
  // ****************************************
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic acc;
  logic wr;
  logic hit;
  logic wake;
  css_stat_t stat;
  css_state_t state_reg, state_next;
  logic [7:0] trim_reg, trim_next;
  assign acc = psel & penable & ~pready_reg;
  assign wr = psel & penable & pready_reg & pwrite;
  assign wake = wr & (paddr == `CSS_OFF_CTRL) & pwdata[`CSS_CTRL_WAKE_BIT];
  always_comb begin
    stat = '0;
    stat.busy = (state_reg != CSS_ST_RUN);
    stat.phase = state_reg;
    stat.src = dec.src;
    stat.range = dec.range;
    stat.startup_time_fuses = fz.startup_time_fuses;
    stat.opt_warn = (dec.src == CSS_SRC_IRC) & ~fz.opt;
    hit = 1'b1;
    prdata_next = prdata_reg;
    case (paddr)
      `CSS_OFF_TRIM: prdata_next = {24'h000000, trim_reg};
      `CSS_OFF_STAT: prdata_next = stat;
      `CSS_OFF_CTRL: prdata_next = 32'h00000000;
      default: begin
        hit = 1'b0;
        prdata_next = 32'h00000000;
      end
    endcase
    if (!acc) begin
      prdata_next = prdata_reg;
    end
    pready_next = acc;
    pslverr_next = acc & ~hit;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // start-up sequencer
  // ****************************************
  logic [16:0] cnt_reg, cnt_next;
  logic gate_reg, gate_next;
  logic wreq_reg, wreq_next;
  css_src_t src_reg, src_next;
  logic [1:0] rng_reg, rng_next;
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    trim_next = trim_reg;
    case (state_reg)
      CSS_ST_LOAD: begin
        if (cnt_reg >= `CSS_LOAD_CYC) begin
          trim_next = cal_sync;
          cnt_next = 17'h00000;
          state_next = (dec.wdt == 17'h00000) ? CSS_ST_CK : CSS_ST_EXTRA;
        end else begin
          cnt_next = cnt_reg + 17'h00001;
        end
      end
      CSS_ST_EXTRA: begin
        if (wdt_tick) begin
          if (cnt_reg >= dec.wdt - 17'h00001) begin
            cnt_next = 17'h00000;
            state_next = CSS_ST_CK;
          end else begin
            cnt_next = cnt_reg + 17'h00001;
          end
        end
      end
      CSS_ST_CK: begin
        if (src_tick) begin
          if (cnt_reg >= dec.ck - 17'h00001) begin
            cnt_next = 17'h00000;
            state_next = CSS_ST_RUN;
          end else begin
            cnt_next = cnt_reg + 17'h00001;
          end
        end
      end
      CSS_ST_RUN: begin
        if (wake) begin
          cnt_next = 17'h00000;
          state_next = CSS_ST_CK;
        end
      end
      default: begin
        state_next = CSS_ST_LOAD;
        cnt_next = 17'h00000;
      end
    endcase
    if (wr && paddr == `CSS_OFF_TRIM && state_reg != CSS_ST_LOAD) begin
      trim_next = pwdata[7:0];
    end
    gate_next = (state_next == CSS_ST_RUN);
    wreq_next = (state_next == CSS_ST_EXTRA);
    src_next = dec.src;
    rng_next = dec.range;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CSS_ST_LOAD;
      cnt_reg <= 17'h00000;
      trim_reg <= `CSS_RST_TRIM;
      gate_reg <= 1'b0;
      wreq_reg <= 1'b0;
      src_reg <= CSS_SRC_IRC;
      rng_reg <= 2'b00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      trim_reg <= trim_next;
      gate_reg <= gate_next;
      wreq_reg <= wreq_next;
      src_reg <= src_next;
      rng_reg <= rng_next;
    end
  end
  assign trim_value = trim_reg;
  assign core_clk_enable = gate_reg;
  assign wdt_osc_request = wreq_reg;
  assign source_kind = src_reg;
  assign source_range = rng_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_lfxt_sel;
    fz.sel == 4'h9 |=> source_kind == CSS_SRC_LFXT;
  endproperty
  a_lfxt_sel: assert property (p_lfxt_sel) else $error("lf crystal not chosen");
  property p_lfxt_long;
    fz.sel == 4'h9 && fz.startup_time_fuses == 2'b10 |-> dec.ck == CK_LONG && dec.wdt == WDT_LONG;
  endproperty
  a_lfxt_long: assert property (p_lfxt_long) else $error("lf crystal delay wrong");
  property p_erc_sel;
    fz.sel == 4'h8 |=> source_kind == CSS_SRC_ERC && source_range == 2'b11;
  endproperty
  a_erc_sel: assert property (p_erc_sel) else $error("rc top range wrong");
  property p_erc_sut3;
    dec.src == CSS_SRC_ERC && fz.startup_time_fuses == 2'b11 |-> dec.ck == 17'h00006 && dec.wdt == 17'h01000;
  endproperty
  a_erc_sut3: assert property (p_erc_sut3) else $error("rc code 11 wrong");
  property p_irc_sel;
    fz.sel == 4'h3 |=> source_kind == CSS_SRC_IRC && source_range == 2'b10;
  endproperty
  a_irc_sel: assert property (p_irc_sel) else $error("internal rc range wrong");
  property p_ext_sel;
    fz.sel == 4'h0 && fz.startup_time_fuses == 2'b00 |-> dec.src == CSS_SRC_EXTCLK && dec.wdt == 17'h00000;
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("external clock decode wrong");
  property p_reserved;
    dec.src == CSS_SRC_IRC && fz.startup_time_fuses == 2'b11 |-> dec.wdt == WDT_LONG;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code not longest");
  property p_cal_load;
    state_reg == CSS_ST_LOAD && cnt_reg >= 17'h00002 |=> trim_value == $past(cal_sync);
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("calibration not loaded");
  property p_gate;
    $rose(core_clk_enable) |-> $past(state_reg) == CSS_ST_CK && $past(src_tick) && state_reg == CSS_ST_RUN;
  endproperty
  a_gate: assert property (p_gate) else $error("core clock released early");
  property p_wake;
    state_reg == CSS_ST_RUN && wake |=> state_reg == CSS_ST_CK ##1 !core_clk_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("wake took reset delay");
  property p_extra_done;
    state_reg == CSS_ST_EXTRA && wdt_tick && cnt_reg >= dec.wdt - 17'h00001
      |=> state_reg == CSS_ST_CK;
  endproperty
  a_extra_done: assert property (p_extra_done) else $error("extra delay overrun");
endmodule

// [verification/css_osc_model.sv]
// oscillator model: source clock and watchdog clock as levels
// assumes the bench clock pclk and a slow-source select
`timescale 1ns/1ns
// ****
// oscillator model
// ****
module css_osc_model (
  input wire logic pclk,
  input wire logic slow,
  output logic src_clk_tick,
  output logic wdt_osc_tick
);
  logic div;
  initial begin
    div = 1'b0;
    src_clk_tick = 1'b0;
    wdt_osc_tick = 1'b0;
  end
  // steady source period, no step between cycles
  always @(posedge pclk) begin
    div <= !div;
    if (!slow || div) begin
      src_clk_tick <= !src_clk_tick;
    end
  end
  // separate free-running watchdog oscillator
  always @(posedge pclk) begin
    wdt_osc_tick <= !wdt_osc_tick;
  end
endmodule

// [verification/css_clock_startup_tb_top.sv]
// bench: boots each clock source with each start-up code except external clock 10, reserved select with 00 only, apb trim access, wake restart
// assumes css_osc_model drives both oscillator ticks
`timescale 1ns/1ns
// ****
// bench top
// ****
module css_clock_startup_tb_top;
  import css_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic pready, pslverr, src_t, wdt_t, req, en, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] cal = 8'h00, trim;
  logic [1:0] rng;
  css_fuse_t fuses = '{4'h1, 2'h2, 1'b1};
  css_src_t kind;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  always #20 pclk = !pclk;
  css_clock_startup #(.EXTRA_LONG_WDT(40), .LFXT_LONG_CK(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuses(fuses), .factory_cal_byte(cal), .src_clk_tick(src_t), .wdt_osc_tick(wdt_t),
    .source_kind(kind), .source_range(rng), .trim_value(trim), .wdt_osc_request(req), .core_clk_enable(en));
  css_osc_model osc (.pclk(pclk), .slow(slow), .src_clk_tick(src_t), .wdt_osc_tick(wdt_t));

  task automatic give_verdict;
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  // cycles until the core clock opens, noting any extra delay
  task automatic wait_en(output int c, output logic s);
    c = 0;
    s = 1'b0;
    while (en !== 1'b1 && c < 20000) begin
      @(posedge pclk);
      c++;
      s |= (req === 1'b1);
    end
    if (c >= 20000) begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  // reset with given fuses; t is start-up plus extra cycles
  task automatic boot(input logic [3:0] s, input logic [1:0] u, input css_src_t k, input logic [1:0] r,
    input int t, input logic w);
    logic sn;
    @(posedge pclk);
    presetn <= 1'b0;
    fuses <= '{s, u, 1'b1};
    cal <= cal + 8'h35;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_en(n, sn);
    chk(32'(kind), 32'(k), "source");
    if (k inside {CSS_SRC_IRC, CSS_SRC_ERC}) chk(32'(rng), 32'(r), "range");
    chk(32'(trim), 32'(cal), "trim load");
    chk(32'(sn), 32'(w), "extra request");
    chk(32'(n >= 2 * t - 2 && n <= 2 * t + 16), 32'h1, "start length");
  endtask

  initial begin
    boot(4'h1, 2'h2, CSS_SRC_IRC, 2'h0, 46, 1'b1);
    apb(1'b0, 12'h000, 32'h0, rd, er);
    chk(rd, 32'(cal), "trim read");
    apb(1'b1, 12'h000, 32'hFFFFFFFF, rd, er);
    apb(1'b0, 12'h000, 32'h0, rd, er);
    chk(rd, 32'h000000FF, "trim max");
    chk(32'(trim), 32'h000000FF, "trim out");
    apb(1'b1, 12'h000, 32'(cal), rd, er);
    apb(1'b1, 12'h004, 32'h0, rd, er);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    chk(rd, 32'h0000020E, "status");
    chk(32'(trim), 32'(cal), "trim restore");
    fuses.opt <= 1'b0;
    apb(1'b0, 12'h004, 32'h0, rd, er);
    chk(rd, 32'h0000060E, "option warning");
    fuses.opt <= 1'b1;
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    chk({rd[30:0], er}, 32'h1, "unmapped");
    slow <= 1'b1;
    apb(1'b1, 12'h008, 32'h1, rd, er);
    repeat (2) @(posedge pclk);
    chk({30'h0, en, req}, 32'h0, "wake gate");
    wait_en(n, er);
    chk({31'h0, er}, 32'h0, "wake extra");
    chk(32'(n >= 20 && n <= 40), 32'h1, "wake length");
    slow <= 1'b0;
    boot(4'h9, 2'h0, CSS_SRC_LFXT, 2'h0, 5120, 1'b1);
    boot(4'h9, 2'h1, CSS_SRC_LFXT, 2'h0, 1064, 1'b1);
    boot(4'h9, 2'h2, CSS_SRC_LFXT, 2'h0, 60, 1'b1);
    boot(4'h9, 2'h3, CSS_SRC_LFXT, 2'h0, 60, 1'b1);
    boot(4'h5, 2'h0, CSS_SRC_ERC, 2'h0, 18, 1'b0);
    boot(4'h6, 2'h1, CSS_SRC_ERC, 2'h1, 4114, 1'b1);
    boot(4'h7, 2'h2, CSS_SRC_ERC, 2'h2, 58, 1'b1);
    boot(4'h8, 2'h3, CSS_SRC_ERC, 2'h3, 4102, 1'b1);
    boot(4'h1, 2'h0, CSS_SRC_IRC, 2'h0, 6, 1'b0);
    boot(4'h2, 2'h1, CSS_SRC_IRC, 2'h1, 4102, 1'b1);
    boot(4'h3, 2'h3, CSS_SRC_IRC, 2'h2, 46, 1'b1);
    boot(4'h4, 2'h2, CSS_SRC_IRC, 2'h3, 46, 1'b1);
    boot(4'h0, 2'h0, CSS_SRC_EXTCLK, 2'h0, 6, 1'b0);
    boot(4'h0, 2'h1, CSS_SRC_EXTCLK, 2'h0, 4102, 1'b1);
    boot(4'h0, 2'h3, CSS_SRC_EXTCLK, 2'h0, 46, 1'b1);
    boot(4'hA, 2'h0, CSS_SRC_NONE, 2'h0, 60, 1'b1);
    give_verdict();
  end
endmodule
